// [hw/pns_consts.vh]
`ifndef PNS_CONSTS_VH
`define PNS_CONSTS_VH

// timing
`define PNS_CLK_PERIOD_NS 25
`define PNS_MS_PERIOD_NS 1000000

// notification modes
`define PNS_MODE_OFF 2'h0
`define PNS_MODE_ITER 2'h1
`define PNS_MODE_MS 2'h2

// register word indexes, byte address = index * 4
`define PNS_IDX_POS 4'h0
`define PNS_IDX_SPOS 4'h1
`define PNS_IDX_RMODE 4'h2
`define PNS_IDX_RIVL 4'h3
`define PNS_IDX_RCHG 4'h4
`define PNS_IDX_RCNT 4'h5
`define PNS_IDX_SMODE 4'h6
`define PNS_IDX_SIVL 4'h7
`define PNS_IDX_SCHG 4'h8
`define PNS_IDX_SCNT 4'h9
`define PNS_IDX_COEF 4'ha
`define PNS_IDX_LOW 4'hb
`define PNS_IDX_HIGH 4'hc
`define PNS_IDX_THR 4'hd
`define PNS_IDX_LAST 4'hd
`define PNS_SLOT_RUPD 4'he
`define PNS_SLOT_SUPD 4'hf

// channel code nibbles: parent level, child level
`define PNS_PAR_RAW 4'h1
`define PNS_PAR_SMO 4'h2
`define PNS_CH_SELF 4'h0
`define PNS_CH_COEF 4'h1
`define PNS_CH_LOW 4'h2
`define PNS_CH_HIGH 4'h3
`define PNS_CH_THR 4'h4
`define PNS_CH_MODE 4'ha
`define PNS_CH_IVL 4'hb
`define PNS_CH_CHG 4'hc
`define PNS_CH_CNT 4'hd

// data values and reset values
`define PNS_ZERO 16'h0000
`define PNS_ONE 16'h0001
`define PNS_IVL_RST 16'h0001
`define PNS_CNT_RST 16'hffff
`define PNS_COEF_RST 16'h0040
`define PNS_LOW_RST 16'h8000
`define PNS_HIGH_RST 16'h7fff
`define PNS_THR_RST 16'h0004
`define PNS_COEF_FRAC 8

`endif

// [hw/pns_notifier.v]
`timescale 1ns/1ps
`include "pns_consts.vh"

module pns_notifier #(
    parameter W = 16
) (
    input wire clock_in, // system clock
    input wire rst_b_in, // synchronised reset, active low
    input wire loop_tick_in, // event-loop iteration pulse
    input wire ms_tick_in, // millisecond pulse
    input wire [W-1:0] pos_in, // value to report
    input wire mode_wr_in, // mode write strobe
    input wire ivl_wr_in, // interval write strobe
    input wire chg_wr_in, // change-only write strobe
    input wire cnt_wr_in, // count write strobe
    input wire [W-1:0] wr_data_in, // written value
    output wire [1:0] mode_out, // current mode
    output wire [W-1:0] ivl_out, // stored interval
    output wire chg_out, // change-only flag
    output wire [W-1:0] cnt_out, // remaining count, signed
    output wire [W-1:0] snap_out, // value of last update
    output wire fire_out, // update due pulse
    output wire stop_out // count ran out pulse
);
    reg [1:0] mode_reg, mode_next;
    reg [W-1:0] ivl_reg, ivl_next;
    reg chg_reg, chg_next;
    reg [W-1:0] cnt_reg, cnt_next;
    reg [W-1:0] tick_reg, tick_next;
    reg [W-1:0] snap_reg, snap_next;
    reg fire_reg, fire_next;
    reg stop_reg, stop_next;
    reg due;

    always @* begin
        mode_next = mode_reg;
        ivl_next = ivl_reg;
        chg_next = chg_reg;
        cnt_next = cnt_reg;
        tick_next = tick_reg;
        snap_next = snap_reg;
        fire_next = 1'b0;
        stop_next = 1'b0;
        // counter saturates once its top bit is set, above any legal interval
        if (!tick_reg[W-1] && ((mode_reg == `PNS_MODE_ITER && loop_tick_in) ||
                (mode_reg == `PNS_MODE_MS && ms_tick_in))) begin
            tick_next = tick_reg + `PNS_ONE;
        end
        due = loop_tick_in && ((mode_reg == `PNS_MODE_ITER && tick_next >= ivl_reg) ||
            (mode_reg == `PNS_MODE_MS && tick_next > ivl_reg));
        if (due && !mode_wr_in && (!chg_reg || pos_in != snap_reg)) begin
            fire_next = 1'b1;
            tick_next = `PNS_ZERO;
            snap_next = pos_in;
            if (!cnt_reg[W-1]) begin
                if (cnt_reg <= `PNS_ONE) begin
                    cnt_next = `PNS_CNT_RST;
                    mode_next = `PNS_MODE_OFF;
                    stop_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg - `PNS_ONE;
                end
            end
        end
        if (ivl_wr_in && !wr_data_in[W-1] && wr_data_in != `PNS_ZERO) begin
            ivl_next = wr_data_in;
        end
        if (chg_wr_in && wr_data_in == `PNS_ONE) begin
            chg_next = 1'b1;
        end else if (chg_wr_in && wr_data_in == `PNS_ZERO) begin
            chg_next = 1'b0;
        end
        if (cnt_wr_in) begin
            cnt_next = wr_data_in;
        end
        if (mode_wr_in && (wr_data_in == {14'h0000, `PNS_MODE_ITER} ||
                wr_data_in == {14'h0000, `PNS_MODE_MS})) begin
            mode_next = wr_data_in[1:0];
            tick_next = `PNS_ZERO;
        end else if (mode_wr_in && wr_data_in == `PNS_ZERO) begin
            mode_next = `PNS_MODE_OFF;
        end
    end

    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_reg <= `PNS_MODE_OFF;
            ivl_reg <= `PNS_IVL_RST;
            chg_reg <= 1'b0;
            cnt_reg <= `PNS_CNT_RST;
            tick_reg <= `PNS_ZERO;
            snap_reg <= `PNS_ZERO;
            fire_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            ivl_reg <= ivl_next;
            chg_reg <= chg_next;
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
            snap_reg <= snap_next;
            fire_reg <= fire_next;
            stop_reg <= stop_next;
        end
    end

    assign mode_out = mode_reg;
    assign ivl_out = ivl_reg;
    assign chg_out = chg_reg;
    assign cnt_out = cnt_reg;
    assign snap_out = snap_reg;
    assign fire_out = fire_reg;
    assign stop_out = stop_reg;
endmodule

// [hw/pns_smoother.v]
`timescale 1ns/1ps
`include "pns_consts.vh"

module pns_smoother #(
    parameter W = 16
) (
    input wire clock_in, // system clock
    input wire rst_b_in, // synchronised reset, active low
    input wire [W-1:0] sample_in, // raw reading, signed
    input wire sample_valid_in, // raw reading strobe
    input wire [W-1:0] coef_in, // weight, fraction of 2^frac
    input wire [W-1:0] low_in, // lower clamp, signed
    input wire [W-1:0] high_in, // upper clamp, signed
    input wire [W-1:0] thr_in, // exit threshold
    output wire [W-1:0] smooth_out, // smoothed value
    output wire constant_out // position held constant
);
    reg [W-1:0] sm_reg;
    reg [W-1:0] held_reg;
    reg const_reg;

    wire signed [W:0] diff = $signed({sample_in[W-1], sample_in}) -
        $signed({sm_reg[W-1], sm_reg});
    wire signed [2*W+1:0] prod = diff * $signed({1'b0, coef_in});
    wire signed [2*W+1:0] step_w = prod >>> `PNS_COEF_FRAC;
    wire signed [W+1:0] sm_ext = $signed({{2{sm_reg[W-1]}}, sm_reg});
    wire signed [W+1:0] cand = sm_ext + $signed(step_w[W+1:0]);
    wire signed [W+1:0] lo = $signed({{2{low_in[W-1]}}, low_in});
    wire signed [W+1:0] hi = $signed({{2{high_in[W-1]}}, high_in});
    wire signed [W+1:0] clamped = (cand < lo) ? lo : ((cand > hi) ? hi : cand);
    wire signed [W+1:0] dev = clamped - $signed({{2{held_reg[W-1]}}, held_reg});
    wire signed [W+1:0] mag = (dev < 0) ? -dev : dev;
    wire leave = mag > $signed({2'b00, thr_in});

    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sm_reg <= `PNS_ZERO;
            held_reg <= `PNS_ZERO;
            const_reg <= 1'b0;
        end else if (sample_valid_in) begin
            if (const_reg) begin
                if (leave) begin
                    const_reg <= 1'b0;
                    sm_reg <= clamped[W-1:0];
                end
            end else begin
                sm_reg <= clamped[W-1:0];
                if (clamped == sm_ext) begin
                    const_reg <= 1'b1;
                    held_reg <= sm_reg;
                end
            end
        end
    end

    assign smooth_out = sm_reg;
    assign constant_out = const_reg;
endmodule

// [hw/pns_position_notify.v]
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "pns_consts.vh"

// Overview of operation
// - each position channel has mode: 0 off, 1 iteration-paced, 2 millisecond-paced.
// - iteration mode sends at most one update every interval loop iterations.
// - millisecond mode checks timer each iteration, sends once timer exceeds interval.
// - change-only skips unchanged positions; write 1 sets, 0 clears, else unchanged.
// - interval write taken only when positive, otherwise kept.
// - negative count means unlimited; nonnegative is updates left to send.
// - parameter write or read answers with the resulting value.
// - mode write 1 or 2 answers first, then updates start.
// - mode write 0 stops updates, then answers on mode channel.
// - other mode values only answer, state unchanged.
// - each update sent with nonnegative count decrements it.
// - count reaching zero becomes -1, stops, answers mode then count.
// - mode read shows 1, 2 while active, 0 when idle.
// - smoothed position is moving average with coefficient, detects constant position.
// - smoothed value is clamped between low and high bounds.
// - constant state left only when change exceeds threshold.
// - smoothed values have a second independent notifier identical to raw one.
// - smoothed position channel is read-only; read answers current value.
// - smoothed notify codes equal raw ones with the parent character swapped.
// - each hierarchy level is one code character, parent prefixes children.
// - top-level character names the actuator; instances independent.
module pns_position_notify #(
    parameter W = 16,
    parameter [7:0] ACT_ID = 8'h70,
    parameter MS_CYCLES = `PNS_MS_PERIOD_NS / `PNS_CLK_PERIOD_NS
) (
    input wire clock_in, // 40 MHz clock
    input wire rst_b_in, // reset, active low
    input wire [7:0] addr_in, // register byte address
    input wire [W-1:0] wr_data_in, // register write data
    input wire wr_en_in, // write strobe
    input wire rd_en_in, // read strobe
    output reg [W-1:0] rd_data_out, // read data, cycle after strobe
    input wire loop_tick_in, // event-loop iteration pulse
    input wire [W-1:0] pos_in, // raw position reading
    input wire pos_valid_in, // raw reading strobe
    input wire msg_ready_in, // host link takes message
    output reg msg_valid_out, // message valid
    output reg [7:0] msg_act_out, // actuator character
    output reg [7:0] msg_chan_out, // channel code
    output reg [W-1:0] msg_payload_out // message payload
);
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_b_sync = rst_sync_reg;

    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // millisecond enable
    reg [31:0] ms_div_reg;
    reg ms_tick_reg;

    always @(posedge clock_in or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            ms_div_reg <= 32'h00000000;
            ms_tick_reg <= 1'b0;
        end else if (ms_div_reg == MS_CYCLES - 1) begin
            ms_div_reg <= 32'h00000000;
            ms_tick_reg <= 1'b1;
        end else begin
            ms_div_reg <= ms_div_reg + 32'h00000001;
            ms_tick_reg <= 1'b0;
        end
    end

    // address decode
    wire [3:0] idx = addr_in[5:2];
    wire map_ok = (addr_in[7:6] == 2'h0) && (addr_in[1:0] == 2'h0) &&
        (idx <= `PNS_IDX_LAST);
    wire wr_hit = wr_en_in && map_ok;
    wire rd_hit = rd_en_in && map_ok;
    wire acc_hit = wr_hit || rd_hit;
    wire w_rmode = wr_hit && idx == `PNS_IDX_RMODE;
    wire w_smode = wr_hit && idx == `PNS_IDX_SMODE;

    // parameter registers
    reg [W-1:0] raw_pos_reg;
    reg [W-1:0] coef_reg;
    reg [W-1:0] low_reg;
    reg [W-1:0] high_reg;
    reg [W-1:0] thr_reg;

    always @(posedge clock_in or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            raw_pos_reg <= `PNS_ZERO;
            coef_reg <= `PNS_COEF_RST;
            low_reg <= `PNS_LOW_RST;
            high_reg <= `PNS_HIGH_RST;
            thr_reg <= `PNS_THR_RST;
        end else begin
            if (pos_valid_in) begin
                raw_pos_reg <= pos_in;
            end
            if (wr_hit && idx == `PNS_IDX_COEF) begin
                coef_reg <= wr_data_in;
            end
            if (wr_hit && idx == `PNS_IDX_LOW) begin
                low_reg <= wr_data_in;
            end
            if (wr_hit && idx == `PNS_IDX_HIGH) begin
                high_reg <= wr_data_in;
            end
            if (wr_hit && idx == `PNS_IDX_THR) begin
                thr_reg <= wr_data_in;
            end
        end
    end

    wire [W-1:0] sm_val;
    wire sm_const;

    pns_smoother #(.W(W)) u_smoother (
        .clock_in(clock_in),
        .rst_b_in(rst_b_sync),
        .sample_in(pos_in),
        .sample_valid_in(pos_valid_in),
        .coef_in(coef_reg),
        .low_in(low_reg),
        .high_in(high_reg),
        .thr_in(thr_reg),
        .smooth_out(sm_val),
        .constant_out(sm_const)
    );

    wire [1:0] r_mode, s_mode;
    wire [W-1:0] r_ivl, s_ivl, r_cnt, s_cnt, r_snap, s_snap;
    wire r_chg, s_chg, r_fire, s_fire, r_stop, s_stop;

    pns_notifier #(.W(W)) u_raw_notifier (
        .clock_in(clock_in),
        .rst_b_in(rst_b_sync),
        .loop_tick_in(loop_tick_in),
        .ms_tick_in(ms_tick_reg),
        .pos_in(raw_pos_reg),
        .mode_wr_in(w_rmode),
        .ivl_wr_in(wr_hit && idx == `PNS_IDX_RIVL),
        .chg_wr_in(wr_hit && idx == `PNS_IDX_RCHG),
        .cnt_wr_in(wr_hit && idx == `PNS_IDX_RCNT),
        .wr_data_in(wr_data_in),
        .mode_out(r_mode),
        .ivl_out(r_ivl),
        .chg_out(r_chg),
        .cnt_out(r_cnt),
        .snap_out(r_snap),
        .fire_out(r_fire),
        .stop_out(r_stop)
    );

    // second notifier reports smoothed values
    pns_notifier #(.W(W)) u_smo_notifier (
        .clock_in(clock_in),
        .rst_b_in(rst_b_sync),
        .loop_tick_in(loop_tick_in),
        .ms_tick_in(ms_tick_reg),
        .pos_in(sm_val),
        .mode_wr_in(w_smode),
        .ivl_wr_in(wr_hit && idx == `PNS_IDX_SIVL),
        .chg_wr_in(wr_hit && idx == `PNS_IDX_SCHG),
        .cnt_wr_in(wr_hit && idx == `PNS_IDX_SCNT),
        .wr_data_in(wr_data_in),
        .mode_out(s_mode),
        .ivl_out(s_ivl),
        .chg_out(s_chg),
        .cnt_out(s_cnt),
        .snap_out(s_snap),
        .fire_out(s_fire),
        .stop_out(s_stop)
    );

    // value carried by a read or by a message slot
    function [W-1:0] slot_val;
        input [3:0] s;
        begin
            case (s)
                `PNS_IDX_POS: slot_val = raw_pos_reg;
                `PNS_IDX_SPOS: slot_val = sm_val;
                `PNS_IDX_RMODE: slot_val = {14'h0000, r_mode};
                `PNS_IDX_RIVL: slot_val = r_ivl;
                `PNS_IDX_RCHG: slot_val = {15'h0000, r_chg};
                `PNS_IDX_RCNT: slot_val = r_cnt;
                `PNS_IDX_SMODE: slot_val = {14'h0000, s_mode};
                `PNS_IDX_SIVL: slot_val = s_ivl;
                `PNS_IDX_SCHG: slot_val = {15'h0000, s_chg};
                `PNS_IDX_SCNT: slot_val = s_cnt;
                `PNS_IDX_COEF: slot_val = coef_reg;
                `PNS_IDX_LOW: slot_val = low_reg;
                `PNS_IDX_HIGH: slot_val = high_reg;
                `PNS_IDX_THR: slot_val = thr_reg;
                `PNS_SLOT_RUPD: slot_val = r_snap;
                `PNS_SLOT_SUPD: slot_val = s_snap;
                default: slot_val = `PNS_ZERO;
            endcase
        end
    endfunction

    // code: parent character, then child character
    function [7:0] chan_of;
        input [3:0] s;
        begin
            case (s)
                `PNS_IDX_POS: chan_of = {`PNS_PAR_RAW, `PNS_CH_SELF};
                `PNS_IDX_SPOS: chan_of = {`PNS_PAR_SMO, `PNS_CH_SELF};
                `PNS_IDX_RMODE: chan_of = {`PNS_PAR_RAW, `PNS_CH_MODE};
                `PNS_IDX_RIVL: chan_of = {`PNS_PAR_RAW, `PNS_CH_IVL};
                `PNS_IDX_RCHG: chan_of = {`PNS_PAR_RAW, `PNS_CH_CHG};
                `PNS_IDX_RCNT: chan_of = {`PNS_PAR_RAW, `PNS_CH_CNT};
                `PNS_IDX_SMODE: chan_of = {`PNS_PAR_SMO, `PNS_CH_MODE};
                `PNS_IDX_SIVL: chan_of = {`PNS_PAR_SMO, `PNS_CH_IVL};
                `PNS_IDX_SCHG: chan_of = {`PNS_PAR_SMO, `PNS_CH_CHG};
                `PNS_IDX_SCNT: chan_of = {`PNS_PAR_SMO, `PNS_CH_CNT};
                `PNS_IDX_COEF: chan_of = {`PNS_PAR_SMO, `PNS_CH_COEF};
                `PNS_IDX_LOW: chan_of = {`PNS_PAR_SMO, `PNS_CH_LOW};
                `PNS_IDX_HIGH: chan_of = {`PNS_PAR_SMO, `PNS_CH_HIGH};
                `PNS_IDX_THR: chan_of = {`PNS_PAR_SMO, `PNS_CH_THR};
                `PNS_SLOT_RUPD: chan_of = {`PNS_PAR_RAW, `PNS_CH_SELF};
                `PNS_SLOT_SUPD: chan_of = {`PNS_PAR_SMO, `PNS_CH_SELF};
                default: chan_of = {`PNS_PAR_RAW, `PNS_CH_SELF};
            endcase
        end
    endfunction

    // pending messages, lowest slot first: answers ahead of updates
    reg [15:0] pend_reg;
    reg [15:0] pend_set;
    reg [15:0] pend_clr;
    reg [3:0] sel;
    reg sel_ok;
    reg take;
    integer i;

    always @* begin
        pend_set = 16'h0000;
        pend_clr = 16'h0000;
        sel = 4'h0;
        sel_ok = 1'b0;
        if (acc_hit) begin
            pend_set[idx] = 1'b1;
        end
        if (r_fire) begin
            pend_set[`PNS_SLOT_RUPD] = 1'b1;
        end
        if (s_fire) begin
            pend_set[`PNS_SLOT_SUPD] = 1'b1;
        end
        if (r_stop) begin
            pend_set[`PNS_IDX_RMODE] = 1'b1;
            pend_set[`PNS_IDX_RCNT] = 1'b1;
        end
        if (s_stop) begin
            pend_set[`PNS_IDX_SMODE] = 1'b1;
            pend_set[`PNS_IDX_SCNT] = 1'b1;
        end
        for (i = 15; i >= 0; i = i - 1) begin
            if (pend_reg[i]) begin
                sel = i[3:0];
                sel_ok = 1'b1;
            end
        end
        take = sel_ok && (!msg_valid_out || msg_ready_in);
        if (take) begin
            pend_clr[sel] = 1'b1;
        end
        // a stop also drops an update fired in this very cycle
        if (w_rmode && wr_data_in == `PNS_ZERO) begin
            pend_set[`PNS_SLOT_RUPD] = 1'b0;
            pend_clr[`PNS_SLOT_RUPD] = 1'b1;
        end
        if (w_smode && wr_data_in == `PNS_ZERO) begin
            pend_set[`PNS_SLOT_SUPD] = 1'b0;
            pend_clr[`PNS_SLOT_SUPD] = 1'b1;
        end
    end

    always @(posedge clock_in or negedge rst_b_sync) begin
        if (!rst_b_sync) begin
            pend_reg <= 16'h0000;
            rd_data_out <= `PNS_ZERO;
            msg_valid_out <= 1'b0;
            msg_act_out <= ACT_ID;
            msg_chan_out <= 8'h00;
            msg_payload_out <= `PNS_ZERO;
        end else begin
            pend_reg <= (pend_reg & ~pend_clr) | pend_set;
            msg_act_out <= ACT_ID;
            rd_data_out <= rd_hit ? slot_val(idx) : `PNS_ZERO;
            if (take) begin
                msg_valid_out <= 1'b1;
                msg_chan_out <= chan_of(sel);
                msg_payload_out <= slot_val(sel);
            end else if (msg_ready_in) begin
                msg_valid_out <= 1'b0;
            end
        end
    end
endmodule

// [test/pns_host_model.sv]
`timescale 1ns/1ps
module pns_host_model (
    input wire clock_in, // clock
    input wire stall_in, // slow host
    output reg ready_out // takes message
);
    reg [1:0] wait_reg = 2'h0;
    initial ready_out = 1'b0;
    // slow host takes about one message in four, never waits over four cycles
    always @(posedge clock_in) begin
        ready_out <= !stall_in || ($urandom % 4 == 0) || wait_reg == 2'h3;
        wait_reg <= ready_out ? 2'h0 : wait_reg + 2'h1;
    end
endmodule

// [test/pns_position_notify_props.sv]
`timescale 1ns/1ps
module pns_position_notify_props #(
    parameter [7:0] ACT_ID = 8'h70
) (
    input wire clock_in, // clock
    input wire rst_b_in, // reset
    input wire [7:0] addr_in, // address
    input wire [15:0] wr_data_in, // write data
    input wire wr_en_in, // write
    input wire rd_en_in, // read
    input wire [15:0] rd_data_out, // read data
    input wire msg_ready_in, // ready
    input wire msg_valid_out, // valid
    input wire [7:0] msg_act_out, // actuator
    input wire [7:0] msg_chan_out, // channel
    input wire [15:0] msg_payload_out // payload
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    rd_idle_a: assert property (!rd_en_in |=> rd_data_out == 16'h0000)
        else $error("read data not zero");
    msg_hold_a: assert property (msg_valid_out && !msg_ready_in |=>
        msg_valid_out && $stable(msg_chan_out) && $stable(msg_payload_out))
        else $error("message changed before taken");
    mode_resp_a: assert property (wr_en_in && addr_in == 8'h08 |->
        ##[2:60] msg_valid_out && msg_chan_out == 8'h1a)
        else $error("no mode response");
    ivl_resp_a: assert property (wr_en_in && addr_in == 8'h0c &&
        wr_data_in == 16'h0003 |-> ##[2:60] msg_valid_out &&
        msg_chan_out == 8'h1b && msg_payload_out == 16'h0003)
        else $error("bad interval response");
    mode_rd_a: assert property (rd_en_in && addr_in[3:0] == 4'h8 &&
        addr_in < 8'h20 |=> rd_data_out <= 16'h0002)
        else $error("mode out of range");
    chg_rd_a: assert property (rd_en_in && (addr_in == 8'h10 ||
        addr_in == 8'h20) |=> rd_data_out <= 16'h0001)
        else $error("change flag out of range");
    ivl_rd_a: assert property (rd_en_in && (addr_in == 8'h0c ||
        addr_in == 8'h1c) |=> rd_data_out != 16'h0000 && !rd_data_out[15])
        else $error("interval not positive");
    act_id_a: assert property (msg_act_out == ACT_ID)
        else $error("actuator code changed");
    chan_par_a: assert property (msg_valid_out |->
        msg_chan_out[7:4] == 4'h1 || msg_chan_out[7:4] == 4'h2)
        else $error("bad parent code");
    raw_upd_c: cover property (msg_valid_out && msg_chan_out == 8'h10);
    smo_upd_c: cover property (msg_valid_out && msg_chan_out == 8'h20);
    stall_c: cover property (msg_valid_out && !msg_ready_in);
endmodule
bind pns_position_notify pns_position_notify_props #(.ACT_ID(ACT_ID)) i_props (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .msg_ready_in(msg_ready_in),
    .msg_valid_out(msg_valid_out), .msg_act_out(msg_act_out),
    .msg_chan_out(msg_chan_out), .msg_payload_out(msg_payload_out));

// [test/pns_position_notify_test.sv]
`timescale 1ns/1ps
module pns_position_notify_test;
    reg clock_in = 1'b0;
    reg rst_b_in = 1'b0;
    reg [7:0] addr_in = 8'h00;
    reg [15:0] wr_data_in = 16'h0000;
    reg wr_en_in = 1'b0;
    reg rd_en_in = 1'b0;
    reg loop_tick_in = 1'b0;
    reg [15:0] pos_in = 16'h0000;
    reg pos_valid_in = 1'b0;
    reg stall = 1'b0;
    wire msg_ready_in;
    wire [15:0] rd_data_out;
    wire msg_valid_out;
    wire [7:0] msg_chan_out;
    wire [15:0] msg_payload_out;
    integer fails = 0;
    integer compares = 0;
    integer cycles = 0;
    integer n_raw = 0;
    integer n_smo = 0;
    integer b;
    reg [15:0] hist = 16'h0000;
    reg [15:0] d;
    reg [15:0] v;
    reg [7:0] a;
    always #12.5 clock_in = ~clock_in;
    pns_position_notify #(.MS_CYCLES(10)) i_pns_position_notify (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out), .loop_tick_in(loop_tick_in), .pos_in(pos_in),
        .pos_valid_in(pos_valid_in), .msg_ready_in(msg_ready_in),
        .msg_valid_out(msg_valid_out), .msg_act_out(), .msg_chan_out(msg_chan_out),
        .msg_payload_out(msg_payload_out));
    pns_host_model i_pns_host_model (
        .clock_in(clock_in), .stall_in(stall), .ready_out(msg_ready_in));
    // tally updates, keep the last two responses
    always @(posedge clock_in) begin
        if (msg_valid_out === 1'b1 && msg_ready_in) begin
            if (msg_chan_out === 8'h10) n_raw <= n_raw + 1;
            else if (msg_chan_out === 8'h20) n_smo <= n_smo + 1;
            else hist <= {hist[7:0], msg_chan_out};
        end
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            give_verdict;
        end
    end
    task chk(input string name, input [15:0] seen, input [15:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input [7:0] ad, input [15:0] val);
        @(posedge clock_in);
        addr_in <= ad;
        wr_data_in <= val;
        wr_en_in <= 1'b1;
        @(posedge clock_in);
        wr_en_in <= 1'b0;
    endtask
    task rd(input [7:0] ad, output [15:0] val);
        @(posedge clock_in);
        addr_in <= ad;
        rd_en_in <= 1'b1;
        @(posedge clock_in);
        rd_en_in <= 1'b0;
        #1 val = rd_data_out;
    endtask
    task tick(input integer n);
        repeat (n) begin
            @(posedge clock_in);
            loop_tick_in <= 1'b1;
            @(posedge clock_in);
            loop_tick_in <= 1'b0;
        end
        repeat (20) @(posedge clock_in);
    endtask
    task sample(input [15:0] val);
        @(posedge clock_in);
        pos_in <= val;
        pos_valid_in <= 1'b1;
        @(posedge clock_in);
        pos_valid_in <= 1'b0;
    endtask
    function [15:0] rst_val(input [3:0] k);
        case (k)
            4'h3, 4'h7: rst_val = 16'h0001;
            4'h5, 4'h9: rst_val = 16'hffff;
            4'ha: rst_val = 16'h0040;
            4'hb: rst_val = 16'h8000;
            4'hc: rst_val = 16'h7fff;
            4'hd: rst_val = 16'h0004;
            default: rst_val = 16'h0000;
        endcase
    endfunction
    initial begin
        void'($urandom(32'h8b1b));
        repeat (6) @(posedge clock_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        for (a = 8'h00; a < 8'h3c; a = a + 8'h04) begin
            rd(a, d);
            chk("reset", d, rst_val(a[5:2]));
        end
        wr(8'h0c, 16'h0000);
        wr(8'h0c, 16'h8000);
        rd(8'h0c, d);
        chk("interval kept", d, 16'h0001);
        wr(8'h10, 16'h0005);
        rd(8'h10, d);
        chk("change kept", d, 16'h0000);
        wr(8'h10, 16'h0001);
        rd(8'h10, d);
        chk("change set", d, 16'h0001);
        wr(8'h10, 16'h0000);
        wr(8'h08, 16'h0003);
        rd(8'h08, d);
        chk("mode kept", d, 16'h0000);
        for (a = 8'h28; a < 8'h38; a = a + 8'h04) begin
            v = 16'($urandom);
            wr(a, v);
            rd(a, d);
            chk("param", d, v);
        end
        wr(8'h28, 16'h0040);
        wr(8'h2c, 16'hff00);
        wr(8'h30, 16'h0100);
        sample(16'h0100);
        rd(8'h04, d);
        chk("smoothed step", d, 16'h0040);
        repeat (40) sample(16'h0200);
        rd(8'h04, d);
        chk("smoothed clamp", d, 16'h0100);
        repeat (30) begin
            sample(16'($urandom));
            rd(8'h04, d);
            chk("smoothed range", {15'h0, $signed(d) >= -256 && $signed(d) <= 256}, 16'h1);
        end
        wr(8'h14, 16'h0002);
        wr(8'h0c, 16'h0003);
        wr(8'h08, 16'h0001);
        b = n_raw;
        tick(30);
        chk("counted updates", 16'(n_raw - b), 16'h0002);
        chk("stop responses", hist, 16'h1a1d);
        rd(8'h08, d);
        chk("mode stopped", d, 16'h0000);
        rd(8'h14, d);
        chk("count rearmed", d, 16'hffff);
        stall <= 1'b1;
        wr(8'h08, 16'h0001);
        b = n_raw;
        tick(12);
        chk("paced updates", 16'(n_raw - b), 16'h0004);
        rd(8'h08, d);
        chk("mode active", d, 16'h0001);
        wr(8'h08, 16'h0000);
        b = n_raw;
        tick(12);
        chk("updates off", 16'(n_raw - b), 16'h0000);
        stall <= 1'b0;
        wr(8'h1c, 16'h0002);
        wr(8'h24, 16'h0001);
        wr(8'h18, 16'h0002);
        b = n_smo;
        repeat (8) begin
            @(posedge clock_in);
            loop_tick_in <= 1'b1;
            @(posedge clock_in);
            loop_tick_in <= 1'b0;
        end
        chk("timer early", 16'(n_smo - b), 16'h0000);
        rd(8'h18, d);
        chk("smoothed mode on", d, 16'h0002);
        tick(20);
        chk("timer update", 16'(n_smo - b), 16'h0001);
        rd(8'h18, d);
        chk("smoothed mode", d, 16'h0000);
        give_verdict;
    end
endmodule
